// ===== ebt_pkg.sv
// shared constants and carrier types of the external bus cycle timer
package ebt_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int H_W = 8;
  // clock figures: pclk 25 ns, bus clock is pclk divided by two
  localparam int PCLK_NS = 25;
  localparam int HALVES_PER_CLK = 2;
  // apb map, byte addresses
  localparam logic [11:0] OFS_TIMING_HIGH = 12'h000;
  localparam logic [11:0] OFS_TIMING_LOW = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  // bus_timing_high fields
  localparam int POS_READ_NOADDR = 0;
  localparam int POS_READ_WITHADDR = 2;
  // bus_timing_low fields
  localparam int POS_CODE_NOADDR = 0;
  localparam int POS_CODE_WITHADDR = 2;
  localparam int POS_LATCH_WIDTH = 4;
  localparam int POS_WRITE_WIDTH = 5;
  localparam int POS_WRITE_HOLD = 6;
  // status fields
  localparam int POS_BUSY = 0;
  localparam int POS_EXT = 8;
  localparam int POS_COUNT = 16;
  // reset values: slowest read and code timing, wide write with hold
  localparam logic [1:0] LEN_RST = 2'h3;
  localparam logic LATCH_WIDTH_RST = 1'b0;
  localparam logic WRITE_WIDTH_RST = 1'b1;
  localparam logic WRITE_HOLD_RST = 1'b1;
  localparam logic BCLK_RST = 1'b0;
  // timing in half bus clocks
  localparam logic [7:0] LAT_NARROW = 8'h01;
  localparam logic [7:0] LAT_WIDE = 8'h03;
  localparam logic [7:0] LAT_GAP = 8'h01;
  localparam logic [7:0] WR_SETUP = 8'h01;
  localparam logic [7:0] WR_NARROW = 8'h03;
  localparam logic [7:0] WR_WIDE = 8'h05;
  localparam logic [7:0] HOLD_HALVES = 8'h02;
  localparam logic [7:0] ONE_CLK = 8'h02;

  typedef enum logic [1:0] {EBT_CODE, EBT_READ, EBT_WRITE} ebt_kind_t;

  typedef struct packed
  {
    ebt_kind_t kind;
    logic with_latch;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebt_req_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic latch_strobe;
    logic code_fetch_strobe_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } ebt_pins_t;

  typedef struct packed
  {
    logic [1:0] code_len_noaddr;
    logic [1:0] code_len_withaddr;
    logic [1:0] read_len_noaddr;
    logic [1:0] read_len_withaddr;
    logic latch_width_select;
    logic write_width_select;
    logic write_hold_select;
  } ebt_timing_t;
endpackage

// ===== ebt_clk_div.sv
// bus clock output divider, one bus clock per two pclk cycles
`timescale 1ns/10ps
module ebt_clk_div
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  output logic bus_clock_output,
  output logic rise_next
);
  typedef struct packed
  {
    logic bclk;
  } ebt_div_t;

  ebt_div_t st;
  ebt_div_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.bclk = ~st.bclk;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{bclk: ebt_pkg::BCLK_RST};
    else if (ce)
      st <= next_st;
  end

  assign bus_clock_output = st.bclk;
  // next pclk edge is a bus clock rising edge
  assign rise_next = ~st.bclk;
endmodule // ebt_clk_div

// ===== ebt_bus_timer.sv
// external bus cycle timer: apb timing registers and half-clock strobe sequencer
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - latch strobe lasts half a clock, or one and a half when widened
// - unlatched code cycle and its strobe last 1 to 4 clocks
// - latched code cycle lasts 2 to 5 clocks in total
// - latched code strobe lasts total minus latch width minus half clock
// - back-to-back unlatched code fetches keep the code strobe low throughout
// - unlatched data read cycle lasts 1 to 4 clocks
// - latched data read cycle lasts 2 to 5 clocks
// - latch strobe rises after bus clock rise, falls after its fall
// - code strobe changes only after bus clock rising edges
// - read strobe changes only after bus clock rising edges
// - write strobe asserts after a falling edge, releases after a rising edge
// - fetched and read data are captured at a bus clock rising edge
// - wait input is sampled only at bus clock rising edges
// - new addresses are driven only after bus clock rising edges
// - write data held one extra clock after the strobe when selected
module ebt_bus_timer
#(
  parameter int MAX_WAIT_CLKS = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire ebt_pkg::ebt_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [ebt_pkg::DATA_W-1:0] rsp_rdata,
  output logic bus_clock_output,
  output ebt_pkg::ebt_pins_t pins,
  input wire logic [ebt_pkg::DATA_W-1:0] data_in,
  input wire logic wait_in
);
  if (MAX_WAIT_CLKS < 1 || MAX_WAIT_CLKS > 100)
  begin : g_chk
    $error("MAX_WAIT_CLKS must lie in 1..100");
  end

  // stretch limit keeps the half counter from wrapping
  localparam logic [7:0] MAX_EXT = 8'(2 * MAX_WAIT_CLKS);

  typedef enum logic {EBT_IDLE, EBT_RUN} ebt_fsm_t;

  typedef struct packed
  {
    ebt_fsm_t fsm;
    logic [7:0] h;
    logic [7:0] lat_end;
    logic [7:0] s_beg;
    logic [7:0] s_end;
    logic [7:0] total;
    logic [7:0] ext;
    logic [1:0] f;
    logic lw;
    logic ww;
    logic hold;
    logic can_wait;
    ebt_pkg::ebt_req_t cur;
    ebt_pkg::ebt_timing_t tm;
    ebt_pkg::ebt_pins_t pins;
    logic rsp;
    logic [ebt_pkg::DATA_W-1:0] rdata;
    logic [31:0] prdata;
    logic [15:0] count;
  } ebt_state_t;

  localparam ebt_state_t ST_RST = '{
    fsm: EBT_IDLE,
    tm: '{code_len_noaddr: ebt_pkg::LEN_RST, code_len_withaddr: ebt_pkg::LEN_RST,
          read_len_noaddr: ebt_pkg::LEN_RST, read_len_withaddr: ebt_pkg::LEN_RST,
          latch_width_select: ebt_pkg::LATCH_WIDTH_RST,
          write_width_select: ebt_pkg::WRITE_WIDTH_RST,
          write_hold_select: ebt_pkg::WRITE_HOLD_RST},
    pins: '{addr: '0, latch_strobe: 1'b0, code_fetch_strobe_n: 1'b1, read_strobe_n: 1'b1,
            write_strobe_n: 1'b1, data_out: '0, data_oe: 1'b0},
    default: '0};

  ebt_state_t st;
  ebt_state_t next_st;
  logic rise_next;
  logic last;
  logic strobe_end_now;
  logic stretch;
  logic done;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // code and read cycle length in halves: 2 * (field + 1 + latch)
  function automatic logic [7:0] cyc_halves(input logic [1:0] f, input logic lat);
    return {5'h00, f, 1'b0} + ebt_pkg::ONE_CLK + (lat ? ebt_pkg::ONE_CLK : 8'h00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == ebt_pkg::OFS_TIMING_HIGH || a == ebt_pkg::OFS_TIMING_LOW || a == ebt_pkg::OFS_STATUS;
  endfunction

  ebt_clk_div i_ebt_clk_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bus_clock_output(bus_clock_output),
    .rise_next(rise_next)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [7:0] lat;
    logic act;
    logic in_str;
    lat = 8'h00;
    act = 1'b0;
    in_str = 1'b0;
    next_st = st;
    next_st.rsp = 1'b0;
    last = st.fsm == EBT_RUN && st.h + 8'h01 == st.total;
    // strobe end always falls on a bus clock rising edge
    strobe_end_now = st.fsm == EBT_RUN && st.h + 8'h01 == st.s_end;
    stretch = strobe_end_now && wait_in && st.can_wait && st.ext < MAX_EXT;
    done = last && !stretch;
    req_ready = (st.fsm == EBT_IDLE || done) && rise_next;

    // apb registers
    if (psel && !penable)
    begin
      unique case (paddr)
        ebt_pkg::OFS_TIMING_HIGH:
        begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[ebt_pkg::POS_READ_NOADDR +: 2] = st.tm.read_len_noaddr;
          next_st.prdata[ebt_pkg::POS_READ_WITHADDR +: 2] = st.tm.read_len_withaddr;
        end
        ebt_pkg::OFS_TIMING_LOW:
        begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[ebt_pkg::POS_CODE_NOADDR +: 2] = st.tm.code_len_noaddr;
          next_st.prdata[ebt_pkg::POS_CODE_WITHADDR +: 2] = st.tm.code_len_withaddr;
          next_st.prdata[ebt_pkg::POS_LATCH_WIDTH] = st.tm.latch_width_select;
          next_st.prdata[ebt_pkg::POS_WRITE_WIDTH] = st.tm.write_width_select;
          next_st.prdata[ebt_pkg::POS_WRITE_HOLD] = st.tm.write_hold_select;
        end
        ebt_pkg::OFS_STATUS:
        begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[ebt_pkg::POS_BUSY] = st.fsm == EBT_RUN;
          next_st.prdata[ebt_pkg::POS_EXT +: 8] = st.ext;
          next_st.prdata[ebt_pkg::POS_COUNT +: 16] = st.count;
        end
        default:
          next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite)
    begin
      if (paddr == ebt_pkg::OFS_TIMING_HIGH)
      begin
        next_st.tm.read_len_noaddr = pwdata[ebt_pkg::POS_READ_NOADDR +: 2];
        next_st.tm.read_len_withaddr = pwdata[ebt_pkg::POS_READ_WITHADDR +: 2];
      end
      else if (paddr == ebt_pkg::OFS_TIMING_LOW)
      begin
        next_st.tm.code_len_noaddr = pwdata[ebt_pkg::POS_CODE_NOADDR +: 2];
        next_st.tm.code_len_withaddr = pwdata[ebt_pkg::POS_CODE_WITHADDR +: 2];
        next_st.tm.latch_width_select = pwdata[ebt_pkg::POS_LATCH_WIDTH];
        next_st.tm.write_width_select = pwdata[ebt_pkg::POS_WRITE_WIDTH];
        next_st.tm.write_hold_select = pwdata[ebt_pkg::POS_WRITE_HOLD];
      end
    end

    // running cycle: wait stretch or data capture at the strobe end
    if (stretch)
    begin
      next_st.s_end = st.s_end + ebt_pkg::ONE_CLK;
      next_st.total = st.total + ebt_pkg::ONE_CLK;
      next_st.ext = st.ext + ebt_pkg::ONE_CLK;
    end
    else if (strobe_end_now && st.cur.kind != ebt_pkg::EBT_WRITE)
      next_st.rdata = data_in;
    if (st.fsm == EBT_RUN)
      next_st.h = st.h + 8'h01;
    if (done)
    begin
      next_st.fsm = EBT_IDLE;
      next_st.rsp = 1'b1;
      next_st.count = st.count + 16'h0001;
    end

    // new cycle always starts on a bus clock rising edge
    if (req_valid && req_ready)
    begin
      next_st.fsm = EBT_RUN;
      next_st.h = 8'h00;
      next_st.ext = 8'h00;
      next_st.cur = req;
      next_st.lw = st.tm.latch_width_select;
      next_st.ww = st.tm.write_width_select;
      next_st.hold = st.tm.write_hold_select;
      if (req.with_latch)
        lat = st.tm.latch_width_select ? ebt_pkg::LAT_WIDE : ebt_pkg::LAT_NARROW;
      next_st.lat_end = lat;
      unique case (req.kind)
        ebt_pkg::EBT_CODE:
        begin
          next_st.f = req.with_latch ? st.tm.code_len_withaddr : st.tm.code_len_noaddr;
          next_st.total = cyc_halves(next_st.f, req.with_latch);
          next_st.s_beg = req.with_latch ? lat + ebt_pkg::LAT_GAP : 8'h00;
          next_st.s_end = next_st.total;
          next_st.can_wait = 1'b1;
        end
        ebt_pkg::EBT_READ:
        begin
          next_st.f = req.with_latch ? st.tm.read_len_withaddr : st.tm.read_len_noaddr;
          next_st.total = cyc_halves(next_st.f, req.with_latch);
          next_st.s_beg = req.with_latch ? lat + ebt_pkg::LAT_GAP : 8'h00;
          next_st.s_end = next_st.total;
          // a single-clock read strobe cannot be stretched
          next_st.can_wait = next_st.s_end - next_st.s_beg > ebt_pkg::ONE_CLK;
        end
        ebt_pkg::EBT_WRITE:
        begin
          next_st.f = 2'h0;
          next_st.s_beg = (req.with_latch ? lat + ebt_pkg::LAT_GAP : 8'h00) + ebt_pkg::WR_SETUP;
          next_st.s_end = next_st.s_beg + (st.tm.write_width_select ? ebt_pkg::WR_WIDE : ebt_pkg::WR_NARROW);
          next_st.total = next_st.s_end + (st.tm.write_hold_select ? ebt_pkg::HOLD_HALVES : 8'h00);
          next_st.can_wait = 1'b1;
        end
        default:
        begin
          next_st.fsm = EBT_IDLE;
          next_st.total = 8'h00;
          next_st.s_beg = 8'h00;
          next_st.s_end = 8'h00;
          next_st.can_wait = 1'b0;
        end
      endcase
    end

    // pins follow the next half index; back-to-back unlatched fetches join windows
    act = next_st.fsm == EBT_RUN;
    in_str = act && next_st.h >= next_st.s_beg && next_st.h < next_st.s_end;
    next_st.pins.addr = next_st.cur.addr;
    next_st.pins.latch_strobe = act && next_st.h < next_st.lat_end;
    next_st.pins.code_fetch_strobe_n = !(in_str && next_st.cur.kind == ebt_pkg::EBT_CODE);
    next_st.pins.read_strobe_n = !(in_str && next_st.cur.kind == ebt_pkg::EBT_READ);
    next_st.pins.write_strobe_n = !(in_str && next_st.cur.kind == ebt_pkg::EBT_WRITE);
    next_st.pins.data_oe = act && next_st.cur.kind == ebt_pkg::EBT_WRITE;
    next_st.pins.data_out = next_st.cur.wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= ST_RST;
    else if (ce)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // a frozen block holds the apb access open
  assign pready = ce;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = st.prdata;
  assign rsp_valid = st.rsp;
  assign rsp_rdata = st.rdata;
  assign pins = st.pins;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  AST_LATCH_NARROW: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(pins.latch_strobe) && !st.lw |=> !pins.latch_strobe)
    else $error("narrow latch strobe not half a clock");
  AST_LATCH_WIDE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(pins.latch_strobe) && st.lw |-> pins.latch_strobe [*3] ##1 !pins.latch_strobe)
    else $error("wide latch strobe not one and a half clocks");
  AST_CODE_LEN: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    done && st.cur.kind == ebt_pkg::EBT_CODE && !st.cur.with_latch
    |-> st.h + 8'h01 == {5'h00, st.f, 1'b0} + 8'h02 + st.ext)
    else $error("unlatched code cycle length wrong");
  AST_CODE_LAT_LEN: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    done && st.cur.kind == ebt_pkg::EBT_CODE && st.cur.with_latch
    |-> st.h + 8'h01 == {5'h00, st.f, 1'b0} + 8'h04 + st.ext)
    else $error("latched code cycle length wrong");
  AST_CODE_LAT_STROBE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $fell(pins.code_fetch_strobe_n) && st.cur.with_latch
    |-> st.h == (st.lw ? 8'h04 : 8'h02))
    else $error("latched code strobe starts at wrong half");
  AST_BURST: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    !pins.code_fetch_strobe_n && req_valid && req_ready && req.kind == ebt_pkg::EBT_CODE
    && !req.with_latch |=> !pins.code_fetch_strobe_n)
    else $error("code strobe toggled inside a burst");
  AST_READ_LEN: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    done && st.cur.kind == ebt_pkg::EBT_READ
    |-> st.h + 8'h01 == {5'h00, st.f, 1'b0} + (st.cur.with_latch ? 8'h04 : 8'h02) + st.ext)
    else $error("data read cycle length wrong");
  AST_LATCH_RISE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(pins.latch_strobe) |-> bus_clock_output)
    else $error("latch strobe rose off the bus clock rise");
  AST_LATCH_FALL: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $fell(pins.latch_strobe) |-> !bus_clock_output)
    else $error("latch strobe fell off the bus clock fall");
  AST_CODE_EDGE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $changed(pins.code_fetch_strobe_n) |-> bus_clock_output)
    else $error("code strobe moved off a rising edge");
  AST_READ_EDGE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $changed(pins.read_strobe_n) |-> bus_clock_output)
    else $error("read strobe moved off a rising edge");
  AST_WRITE_EDGE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    ($fell(pins.write_strobe_n) |-> !bus_clock_output) and ($rose(pins.write_strobe_n) |-> bus_clock_output))
    else $error("write strobe edge on wrong bus clock edge");
  AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    strobe_end_now && !stretch && st.cur.kind != ebt_pkg::EBT_WRITE |=> rsp_rdata == $past(data_in))
    else $error("read data not captured at strobe end");
  AST_WAIT_EDGE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    strobe_end_now |-> rise_next)
    else $error("wait sampled off a rising edge");
  AST_ADDR_EDGE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $changed(pins.addr) |-> bus_clock_output)
    else $error("address changed off a rising edge");
  AST_WR_WIDTH: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*3] ##1 (st.ww ? !pins.write_strobe_n : 1'b1))
    else $error("write strobe too short");
  AST_WR_HOLD: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(pins.write_strobe_n) && st.hold |-> pins.data_oe [*2])
    else $error("write data not held");
  AST_WAIT_EXT: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    stretch |=> st.fsm == EBT_RUN && !done ##1 st.fsm == EBT_RUN)
    else $error("wait did not stretch the cycle");
endmodule // ebt_bus_timer

// ===== ebt_mem_model.sv
// behavioural external memory answering the bus timer pins
`timescale 1ns/10ps
module ebt_mem_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ebt_pkg::ebt_pins_t pins,
  input wire logic [3:0] wait_hold,
  output logic [15:0] data_in,
  output logic wait_in
);
  logic [3:0] held;
  logic strobe_on;
  assign strobe_on = !pins.code_fetch_strobe_n || !pins.read_strobe_n || !pins.write_strobe_n;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_in <= 16'h0000;
      wait_in <= 1'b0;
      held <= 4'h0;
    end
    else
    begin
      // released bus toggles so a late capture never sees stale data
      if (!pins.code_fetch_strobe_n || !pins.read_strobe_n)
        data_in <= pins.addr[15:0] ^ 16'h5A3C;
      else
        data_in <= ~data_in;
      // wait rises one pclk after a strobe goes low and stays high for at most wait_hold pclk cycles
      wait_in <= strobe_on && (held < wait_hold);
      held <= strobe_on ? held + 4'h1 : 4'h0;
    end
  end
endmodule // ebt_mem_model

// ===== test_external_bus_cycle_timer.sv
// self-checking testbench of the external bus cycle timer
`timescale 1ns/10ps
module test_external_bus_cycle_timer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, rsp_valid, bco, wait_in;
  logic ok, rdy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rsp_rdata, data_in, wexp;
  logic [23:0] aa;
  logic [3:0] wait_hold;
  ebt_pkg::ebt_req_t req;
  ebt_pkg::ebt_pins_t pins, prev;
  int err_count, n_compared, t, tt, ll;
  // 0 code low, 1 read low, 2 write low, 3 latch high, 4 drive, 5 code releases
  int cnt [6];
  ebt_bus_timer #(.MAX_WAIT_CLKS(4)) i_ebt_bus_timer (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_clock_output(bco), .pins(pins),
    .data_in(data_in), .wait_in(wait_in));
  ebt_mem_model i_ebt_mem_model (.pclk(pclk), .presetn(presetn), .pins(pins), .wait_hold(wait_hold),
    .data_in(data_in), .wait_in(wait_in));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    ok = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cfg(input logic [3:0] hi, input logic [6:0] lo);
    apb(1'b1, ebt_pkg::OFS_TIMING_HIGH, {28'h0, hi});
    apb(1'b1, ebt_pkg::OFS_TIMING_LOW, {25'h0, lo});
  endtask
  // request is held until the design takes it
  task take;
    rdy = 1'b0;
    while (!rdy)
    begin
      @(negedge pclk);
      rdy = req_ready;
      @(posedge pclk);
    end
  endtask
  task cycle(input ebt_pkg::ebt_kind_t k, input logic lat, input logic [23:0] a);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= {k, lat, a, wexp};
    take();
    req_valid <= 1'b0;
    cnt = '{default:0};
    t = -1;
    do
    begin
      @(negedge pclk);
      t++;
    end
    while (!rsp_valid);
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge pclk)
  begin
    if (presetn)
    begin
      if (pins.latch_strobe !== prev.latch_strobe) check(bco, !prev.latch_strobe, "latch edge");
      if (pins.code_fetch_strobe_n !== prev.code_fetch_strobe_n) check(bco, 1, "code edge");
      if (pins.read_strobe_n !== prev.read_strobe_n) check(bco, 1, "read edge");
      if (pins.write_strobe_n !== prev.write_strobe_n) check(bco, !prev.write_strobe_n, "write edge");
      if (pins.addr !== prev.addr) check(bco, 1, "addr edge");
      if (pins.data_oe) check(pins.data_out, wexp, "wdata");
      cnt[0] += !pins.code_fetch_strobe_n;
      cnt[1] += !pins.read_strobe_n;
      cnt[2] += !pins.write_strobe_n;
      cnt[3] += pins.latch_strobe;
      cnt[4] += pins.data_oe;
      cnt[5] += pins.code_fetch_strobe_n && !prev.code_fetch_strobe_n;
    end
    prev = pins;
  end
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #(ebt_pkg::PCLK_NS * 20000);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, req_valid} = '0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    wait_hold = 4'h0;
    wexp = 16'h0000;
    err_count = 0;
    n_compared = 0;
    cnt = '{default:0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ebt_pkg::OFS_TIMING_HIGH, 32'h0);
    check(rd, 32'h0000000F, "high reset");
    apb(1'b0, ebt_pkg::OFS_TIMING_LOW, 32'h0);
    check(rd, 32'h0000006F, "low reset");
    apb(1'b0, 12'h00C, 32'h0);
    check({rd[30:0], ok}, 32'h1, "unmapped");
    // every field value, unlatched and latched, code and read
    for (int f = 0; f < 4; f++)
      for (int lat = 0; lat < 2; lat++)
        for (int k = 0; k < 2; k++)
        begin
          cfg({f[1:0], f[1:0]}, {2'h2, f[0], f[1:0], f[1:0]});
          aa = 24'h012300 + 24'(f * 16 + lat * 4 + k * 2);
          cycle(k ? ebt_pkg::EBT_READ : ebt_pkg::EBT_CODE, lat[0], aa);
          tt = 2 * (f + 1 + lat);
          ll = f[0] ? 3 : 1;
          check(t, tt, "cycle len");
          check(cnt[k], lat ? tt - ll - 1 : tt, "strobe len");
          check(cnt[3], lat ? ll : 0, "latch len");
          check(rsp_rdata, aa[15:0] ^ 16'h5A3C, "rdata");
        end
    // write width and hold combinations
    for (int m = 0; m < 4; m++)
    begin
      cfg(4'h0, {m[1:0], 5'h00});
      wexp = 16'hC350 + 16'(m);
      cycle(ebt_pkg::EBT_WRITE, 1'b0, 24'h00F000);
      check(cnt[2], m[0] ? 5 : 3, "write len");
      check(t, (m[0] ? 6 : 4) + 2 * m[1], "write cycle");
      check(cnt[4], (m[0] ? 6 : 4) + 2 * m[1], "drive len");
    end
    // two-clock read so that wait can stretch it
    cfg(4'h1, 7'h40);
    // wait high for six halves: sampled high at two strobe ends, so two stretches
    wait_hold <= 4'h6;
    cycle(ebt_pkg::EBT_READ, 1'b0, 24'h000200);
    check(t, 8, "wait cycle");
    check(cnt[1], 8, "wait strobe");
    wait_hold <= 4'h0;
    apb(1'b0, ebt_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0015_0400, "status");
    // back-to-back unlatched code fetches keep the strobe low
    cfg(4'h0, 7'h41);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= {ebt_pkg::EBT_CODE, 1'b0, 24'h000400, 16'h0000};
    take();
    cnt = '{default:0};
    req.addr <= 24'h000402;
    take();
    req_valid <= 1'b0;
    @(negedge pclk);
    do
      @(negedge pclk);
    while (!rsp_valid);
    @(posedge pclk);
    check(cnt[0], 8, "burst low");
    check(cnt[5], 1, "burst release");
    check(rsp_rdata, 16'h0402 ^ 16'h5A3C, "burst data");
    report_and_stop();
  end
endmodule // test_external_bus_cycle_timer
